// [inc/lane_map_pkg.sv]
// Constants shared by the frame lane mapper and its frame buffer
//
// Overview of operation
// - Mode 1, 8B/10B, 6/3/2 lanes: lane 0 A0,000,A1[8:5]; lane 1 A1[4:0],000,B0[8:1].
// - Mode 1 lane 2 B0[0],000,B1,000; quad lanes 3-5 repeat with C and D.
// - Mode 2, 8B/10B, 4/2/1 lanes, one 8-bit octet per lane, channels A-D.
// - Mode 3, 8B/10B, 4/2/1 lanes, five octets: four samples each plus zero bit.
// - Mode 4, 64B/66B, 3/2/1 lanes: lane 0 A0,000,B0[8:5]; lane 1 B0[4:0],000,C0[8:1].
// - Mode 4 quad lane 2 carries C0[0],000 then D0,000.
// - Mode 5, 64B/66B, 2/1/1 lanes: lane 0 A0 then B0; quad lane 1 C0,D0.
// - Mode 6 uses the mode 1 bit layout over 6/3/2 lanes with 64B/66B.
// - Mode 7, 64B/66B, 4/2/1 lanes, one 8-bit octet per lane, channels A-D.
// - Mode 8, 64B/66B, 4/2/1 lanes, three octets: two samples each plus 000.
// - Mode 9, 8B/10B, 8/4/2 lanes, lanes 0-7 carry A0,A1,B0,B1,C0,C1,D0,D1.
// - Samples go MSB first; padding low bits and tail bits are zero.
// - Use lowest lanes for the mode; power down all higher lanes.
package lane_map_pkg;
  localparam int SAMPLE_W = 9;
  localparam int SAMPLES_PER_CH = 4;
  localparam int CHANNELS = 4;
  localparam int FRAME_W = SAMPLE_W * SAMPLES_PER_CH * CHANNELS;
  localparam int LANES = 8;
  localparam int LANE_W = 40;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] FMT_M1 = 4'h1;
  localparam logic [3:0] FMT_M2 = 4'h2;
  localparam logic [3:0] FMT_M3 = 4'h3;
  localparam logic [3:0] FMT_M4 = 4'h4;
  localparam logic [3:0] FMT_M5 = 4'h5;
  localparam logic [3:0] FMT_M6 = 4'h6;
  localparam logic [3:0] FMT_M7 = 4'h7;
  localparam logic [3:0] FMT_M8 = 4'h8;
  localparam logic [3:0] FMT_M9 = 4'h9;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] PART_QUAD = 2'h0;
  localparam logic [1:0] PART_DUAL = 2'h1;
  localparam logic [1:0] PART_SINGLE = 2'h2;
  localparam logic [1:0] PART_RESET = PART_QUAD;
endpackage

// [inc/frame_stream_if.sv]
// Valid/ready stream carrying one frame word
`timescale 1ns/1ns
`default_nettype none
interface frame_stream_if #(parameter int W = 144);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// [design/frame_fifo.sv]
// Frame buffer with registered read data
`timescale 1ns/1ns
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 144,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  frame_stream_if.snk wr,
  frame_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  wire logic push;
  wire logic load;
  assign wr.ready = count != FULL_COUNT;
  assign push = wr.valid && wr.ready;
  // Refill output stage when empty or being drained
  assign load = (count != '0) && (!rvalid || rd.ready);
  assign rd.valid = rvalid;
  assign rd.data = rdata;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wp] <= wr.data;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= AW'(wp + 1'b1);
      end
      if (load)
      begin
        rp <= AW'(rp + 1'b1);
        rdata <= mem[rp];
        rvalid <= 1'b1;
      end
      else if (rd.ready)
      begin
        rvalid <= 1'b0;
      end
      if (push && !load)
      begin
        count <= (AW+1)'(count + 1'b1);
      end
      else if (load && !push)
      begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// [design/adc_sample_lane_mapper.sv]
// Transport frame mapper: packs converter samples into lane octets per format mode
`timescale 1ns/1ns
`default_nettype none
module adc_sample_lane_mapper (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic [3:0] LINK_FORMAT_MODE_IN,
  input wire logic [1:0] PART_VARIANT_IN,
  input wire logic SAMPLE_VALID_IN,
  output logic SAMPLE_READY_OUT,
  input wire logic [143:0] SAMPLE_DATA_IN,
  output logic LANE_VALID_OUT,
  input wire logic LANE_READY_IN,
  output logic [319:0] LANE_DATA_OUT,
  output logic [2:0] LANE_OCTETS_OUT,
  output logic [7:0] LANE_POWER_OUT,
  output logic LINK_64B66B_OUT
);
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_HOLD = 1'b1} out_state_e;

  // Sample n of channel ch (A=0) from a frame word
  function automatic logic [8:0] smp(input logic [143:0] f, input int ch, input int n);
    return f[(ch * lane_map_pkg::SAMPLES_PER_CH + n) * lane_map_pkg::SAMPLE_W +: 9];
  endfunction

  function automatic logic [3:0] lane_count(input logic [3:0] m, input logic [1:0] v);
    logic [3:0] r;
    logic q;
    logic d;
    r = 4'h0;
    q = v == lane_map_pkg::PART_QUAD;
    d = v == lane_map_pkg::PART_DUAL;
    case (m)
      lane_map_pkg::FMT_M1, lane_map_pkg::FMT_M6: r = q ? 4'h6 : (d ? 4'h3 : 4'h2);
      lane_map_pkg::FMT_M2, lane_map_pkg::FMT_M3,
      lane_map_pkg::FMT_M7, lane_map_pkg::FMT_M8: r = q ? 4'h4 : (d ? 4'h2 : 4'h1);
      lane_map_pkg::FMT_M4: r = q ? 4'h3 : (d ? 4'h2 : 4'h1);
      lane_map_pkg::FMT_M5: r = q ? 4'h2 : 4'h1;
      lane_map_pkg::FMT_M9: r = q ? 4'h8 : (d ? 4'h4 : 4'h2);
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] octet_count(input logic [3:0] m);
    logic [2:0] r;
    r = 3'h0;
    case (m)
      lane_map_pkg::FMT_M1, lane_map_pkg::FMT_M4,
      lane_map_pkg::FMT_M5, lane_map_pkg::FMT_M6: r = 3'h2;
      lane_map_pkg::FMT_M2, lane_map_pkg::FMT_M7, lane_map_pkg::FMT_M9: r = 3'h1;
      lane_map_pkg::FMT_M3: r = 3'h5;
      lane_map_pkg::FMT_M8: r = 3'h3;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // Octet 0 sits in bits 39:32; unused trailing octets stay zero
  function automatic logic [39:0] map_lane(input logic [143:0] f, input logic [3:0] m,
                                           input logic [1:0] v, input int l);
    logic [39:0] r;
    logic q;
    logic s;
    int c0;
    int c1;
    int k;
    int ch;
    r = 40'h0;
    q = v == lane_map_pkg::PART_QUAD;
    s = v != lane_map_pkg::PART_QUAD && v != lane_map_pkg::PART_DUAL;
    c0 = 2 * (l / 3);
    c1 = c0 + 1;
    k = l % 3;
    ch = l % 4;
    if (l < int'(lane_count(m, v)))
    begin
      case (m)
        lane_map_pkg::FMT_M1, lane_map_pkg::FMT_M6:
        begin
          if (k == 0)
          begin
            r = {smp(f, c0, 0), 3'h0, 4'(smp(f, c0, 1) >> 5), 24'h0};
          end
          else if (k == 1)
          begin
            r = {5'(smp(f, c0, 1)), 3'h0, s ? 8'h00 : 8'(smp(f, c1, 0) >> 1), 24'h0};
          end
          else
          begin
            r = {1'(smp(f, c1, 0)), 3'h0, smp(f, c1, 1), 3'h0, 24'h0};
          end
        end
        lane_map_pkg::FMT_M2, lane_map_pkg::FMT_M7:
          r = {8'(smp(f, ch, 0) >> 1), 32'h0};
        lane_map_pkg::FMT_M3:
          r = {smp(f, ch, 0), 1'b0, smp(f, ch, 1), 1'b0, smp(f, ch, 2), 1'b0,
               smp(f, ch, 3), 1'b0};
        lane_map_pkg::FMT_M4:
        begin
          if (l == 0)
          begin
            r = {smp(f, 0, 0), 3'h0, s ? 4'h0 : 4'(smp(f, 1, 0) >> 5), 24'h0};
          end
          else if (l == 1)
          begin
            r = {5'(smp(f, 1, 0)), 3'h0, q ? 8'(smp(f, 2, 0) >> 1) : 8'h00, 24'h0};
          end
          else
          begin
            r = {1'(smp(f, 2, 0)), 3'h0, smp(f, 3, 0), 3'h0, 24'h0};
          end
        end
        lane_map_pkg::FMT_M5:
        begin
          if (l == 0)
          begin
            r = {8'(smp(f, 0, 0) >> 1), s ? 8'h00 : 8'(smp(f, 1, 0) >> 1), 24'h0};
          end
          else
          begin
            r = {8'(smp(f, 2, 0) >> 1), 8'(smp(f, 3, 0) >> 1), 24'h0};
          end
        end
        lane_map_pkg::FMT_M8:
          r = {smp(f, ch, 0), 3'h0, smp(f, ch, 1), 3'h0, 16'h0};
        lane_map_pkg::FMT_M9:
          r = {8'(smp(f, l / 2, l % 2) >> 1), 32'h0};
        default:
          r = 40'h0;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] lane_mask(input logic [3:0] n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < lane_map_pkg::LANES; i++)
    begin
      r[i] = i < int'(n);
    end
    return r;
  endfunction

  logic [5:0] cfg_s1;
  logic [5:0] cfg_s2;
  logic [5:0] cfg_s3;
  logic [3:0] cfg_mode;
  logic [1:0] cfg_variant;
  out_state_e state;
  out_state_e next_state;
  wire logic [143:0] head_data;
  wire logic supported;
  wire logic out_free;
  wire logic take;
  wire logic [319:0] next_lanes;
  wire logic [39:0] lane_q [8];

  frame_stream_if #(.W(lane_map_pkg::FRAME_W)) in_if ();
  frame_stream_if #(.W(lane_map_pkg::FRAME_W)) out_if ();

  assign in_if.valid = SAMPLE_VALID_IN;
  assign in_if.data = SAMPLE_DATA_IN;
  assign SAMPLE_READY_OUT = in_if.ready;

  frame_fifo #(.WIDTH(lane_map_pkg::FRAME_W), .DEPTH(lane_map_pkg::FIFO_DEPTH)) buffer (
    .clk_in(CLK_SYS_IN),
    .rst_in(SYS_RST_IN),
    .wr(in_if.snk),
    .rd(out_if.src)
  );

  assign head_data = out_if.data;
  assign supported = lane_count(cfg_mode, cfg_variant) != 4'h0;
  assign out_free = state == ST_IDLE || LANE_READY_IN;
  // Frames under an unsupported mode are drained and discarded
  assign out_if.ready = supported ? out_free : 1'b1;
  assign take = out_if.valid && supported && out_free;
  assign LANE_VALID_OUT = state == ST_HOLD;

  for (genvar g = 0; g < lane_map_pkg::LANES; g++)
  begin : g_lane
    assign next_lanes[g*40 +: 40] = map_lane(head_data, cfg_mode, cfg_variant, g);
    assign lane_q[g] = LANE_DATA_OUT[g*40 +: 40];
  end

  // Mode pins are static straps; accept once two late stages agree
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      cfg_s1 <= 6'h00;
      cfg_s2 <= 6'h00;
      cfg_s3 <= 6'h00;
      cfg_mode <= lane_map_pkg::MODE_RESET;
      cfg_variant <= lane_map_pkg::PART_RESET;
    end
    else
    begin
      cfg_s1 <= {LINK_FORMAT_MODE_IN, PART_VARIANT_IN};
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      if (cfg_s2 == cfg_s3)
      begin
        {cfg_mode, cfg_variant} <= cfg_s3;
      end
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = take ? ST_HOLD : ST_IDLE;
      ST_HOLD: next_state = (LANE_READY_IN && !take) ? ST_IDLE : ST_HOLD;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state <= ST_IDLE;
      LANE_DATA_OUT <= '0;
      LANE_OCTETS_OUT <= 3'h0;
      LANE_POWER_OUT <= 8'h00;
      LINK_64B66B_OUT <= 1'b0;
    end
    else
    begin
      state <= next_state;
      LANE_POWER_OUT <= lane_mask(lane_count(cfg_mode, cfg_variant));
      LINK_64B66B_OUT <= cfg_mode >= lane_map_pkg::FMT_M4 && cfg_mode <= lane_map_pkg::FMT_M8;
      if (take)
      begin
        LANE_DATA_OUT <= next_lanes;
        LANE_OCTETS_OUT <= octet_count(cfg_mode);
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_take(logic [3:0] m);
    take && cfg_mode == m;
  endsequence

  sequence s_take_quad(logic [3:0] m);
    s_take(m) ##0 cfg_variant == lane_map_pkg::PART_QUAD;
  endsequence

  a_m1_lane0_form: assert property (s_take(lane_map_pkg::FMT_M1) |=>
    lane_q[0] == {smp($past(head_data), 0, 0), 3'h0, 4'(smp($past(head_data), 0, 1) >> 5),
    24'h0})
    else $error("mode 1 lane 0 layout wrong");
  a_m1_quad_lane5: assert property (s_take_quad(lane_map_pkg::FMT_M1) |=>
    lane_q[5] == {1'(smp($past(head_data), 3, 0)), 3'h0, smp($past(head_data), 3, 1),
    27'h0})
    else $error("mode 1 lane 5 layout wrong");
  a_m2_lane_octet: assert property (s_take_quad(lane_map_pkg::FMT_M2) |=>
    lane_q[2] == {8'(smp($past(head_data), 2, 0) >> 1), 32'h0})
    else $error("mode 2 lane 2 octet wrong");
  a_m3_five_octets: assert property (s_take(lane_map_pkg::FMT_M3) |=>
    lane_q[0] == {smp($past(head_data), 0, 0), 1'b0, smp($past(head_data), 0, 1), 1'b0,
    smp($past(head_data), 0, 2), 1'b0, smp($past(head_data), 0, 3), 1'b0}
    && LANE_OCTETS_OUT == 3'h5)
    else $error("mode 3 lane 0 layout wrong");
  a_m4_lane1_form: assert property (s_take_quad(lane_map_pkg::FMT_M4) |=>
    lane_q[1] == {5'(smp($past(head_data), 1, 0)), 3'h0,
    8'(smp($past(head_data), 2, 0) >> 1), 24'h0})
    else $error("mode 4 lane 1 layout wrong");
  a_m4_lane2_form: assert property (s_take_quad(lane_map_pkg::FMT_M4) |=>
    lane_q[2][39:24] == {1'(smp($past(head_data), 2, 0)), 3'h0,
    smp($past(head_data), 3, 0), 3'h0})
    else $error("mode 4 lane 2 layout wrong");
  a_m5_single_pad: assert property (s_take(lane_map_pkg::FMT_M5) ##0
    cfg_variant == lane_map_pkg::PART_SINGLE |=> lane_q[0][31:0] == 32'h0
    && LANE_POWER_OUT == 8'h01)
    else $error("mode 5 single lane 0 padding wrong");
  a_m6_m1_layout: assert property (s_take_quad(lane_map_pkg::FMT_M6) |=>
    lane_q[4] == {5'(smp($past(head_data), 2, 1)), 3'h0,
    8'(smp($past(head_data), 3, 0) >> 1), 24'h0} && LINK_64B66B_OUT)
    else $error("mode 6 lane 4 layout wrong");
  a_m7_lane_octet: assert property (s_take_quad(lane_map_pkg::FMT_M7) |=>
    lane_q[3] == {8'(smp($past(head_data), 3, 0) >> 1), 32'h0})
    else $error("mode 7 lane 3 octet wrong");
  a_m8_containers: assert property (s_take(lane_map_pkg::FMT_M8) |=>
    lane_q[0][39:16] == {smp($past(head_data), 0, 0), 3'h0, smp($past(head_data), 0, 1),
    3'h0} && LANE_OCTETS_OUT == 3'h3)
    else $error("mode 8 lane 0 layout wrong");
  a_m9_lane_order: assert property (s_take_quad(lane_map_pkg::FMT_M9) |=>
    lane_q[6][39:32] == smp($past(head_data), 3, 0) >> 1
    && lane_q[1][39:32] == smp($past(head_data), 0, 1) >> 1)
    else $error("mode 9 lane order wrong");
  a_m9_lane7_d1: assert property (s_take_quad(lane_map_pkg::FMT_M9) |=>
    lane_q[7] == {8'(smp($past(head_data), 3, 1) >> 1), 32'h0})
    else $error("mode 9 lane 7 not D1");
  a_unused_lanes_zero: assert property (take ##0 lane_count(cfg_mode, cfg_variant) == 4'h2
    |=> LANE_DATA_OUT[319:80] == '0)
    else $error("powered-down lane carries data");
  a_power_follows: assert property ($stable(cfg_mode) && $stable(cfg_variant) |=>
    LANE_POWER_OUT == lane_mask(lane_count($past(cfg_mode), $past(cfg_variant))))
    else $error("lane power mask mismatch");
  a_hold_stable: assert property (LANE_VALID_OUT && !LANE_READY_IN |=>
    LANE_VALID_OUT && $stable(LANE_DATA_OUT))
    else $error("lane frame changed while stalled");
endmodule
`default_nettype wire

// [verification/lane_rx_model.sv]
// Downstream lane receiver model with random back-pressure
`timescale 1ns/1ns
`default_nettype none
module lane_rx_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] busy_pct_in,
  input wire logic hold_in,
  output logic ready_out
);
  // Ready moves at the falling edge only; the bench packs expected frames with the same mode and part
  always @(negedge clk_in or posedge rst_in)
    if (rst_in)
      ready_out <= 1'b0;
    else if (hold_in)
      ready_out <= 1'b0;
    else
      ready_out <= ($urandom_range(99) >= int'(busy_pct_in));
endmodule
`default_nettype wire

// [verification/tb_adc_sample_lane_mapper.sv]
// Self-checking bench for the lane mapper
`timescale 1ns/1ns
`default_nettype none
module tb_adc_sample_lane_mapper;
  localparam int LN [10][3] = '{'{0, 0, 0}, '{6, 3, 2}, '{4, 2, 1}, '{4, 2, 1}, '{3, 2, 1},
    '{2, 1, 1}, '{6, 3, 2}, '{4, 2, 1}, '{4, 2, 1}, '{8, 4, 2}};
  localparam int OCT [10] = '{0, 2, 1, 5, 2, 2, 2, 1, 3, 1};
  logic CLK_SYS_IN, SYS_RST_IN, SAMPLE_VALID_IN, SAMPLE_READY_OUT, LANE_VALID_OUT;
  logic LANE_READY_IN, LINK_64B66B_OUT, hold;
  logic [3:0] mode;
  logic [1:0] part;
  logic [143:0] SAMPLE_DATA_IN;
  logic [319:0] LANE_DATA_OUT, ed;
  logic [2:0] LANE_OCTETS_OUT, eo;
  logic [7:0] LANE_POWER_OUT, busy;
  logic [319:0] exp_q [$];
  int err_count, n_checks, taken;

  adc_sample_lane_mapper adc_sample_lane_mapper_i (.CLK_SYS_IN(CLK_SYS_IN),
    .SYS_RST_IN(SYS_RST_IN), .LINK_FORMAT_MODE_IN(mode), .PART_VARIANT_IN(part),
    .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SAMPLE_READY_OUT(SAMPLE_READY_OUT),
    .SAMPLE_DATA_IN(SAMPLE_DATA_IN), .LANE_VALID_OUT(LANE_VALID_OUT),
    .LANE_READY_IN(LANE_READY_IN), .LANE_DATA_OUT(LANE_DATA_OUT),
    .LANE_OCTETS_OUT(LANE_OCTETS_OUT), .LANE_POWER_OUT(LANE_POWER_OUT),
    .LINK_64B66B_OUT(LINK_64B66B_OUT));
  lane_rx_model lane_rx_model_i (.clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN),
    .busy_pct_in(busy), .hold_in(hold), .ready_out(LANE_READY_IN));

  initial
  begin
    CLK_SYS_IN = 1'b0;
    forever #4 CLK_SYS_IN = ~CLK_SYS_IN;
  end

  function automatic int pidx(logic [1:0] p);
    return (p > 2'h1) ? 2 : int'(p);
  endfunction

  // Reference packing; channels absent on the part read as zero
  function automatic logic [319:0] map_frame(logic [3:0] m, logic [1:0] p, logic [143:0] f);
    logic [8:0] s [4][4];
    logic [319:0] r;
    r = '0;
    for (int c = 0; c < 4; c++)
      for (int n = 0; n < 4; n++)
        s[c][n] = (c < (4 >> pidx(p))) ? f[(c * 4 + n) * 9 +: 9] : 9'h0;
    case (m)
      4'h1, 4'h6:
        for (int g = 0; g < 2; g++)
        begin
          r[g * 120 +: 40] = {s[2 * g][0], 3'h0, s[2 * g][1][8:5], 24'h0};
          r[g * 120 + 40 +: 40] = {s[2 * g][1][4:0], 3'h0, s[2 * g + 1][0][8:1], 24'h0};
          r[g * 120 + 80 +: 40] = {s[2 * g + 1][0][0], 3'h0, s[2 * g + 1][1], 3'h0, 24'h0};
        end
      4'h2, 4'h7:
        for (int c = 0; c < 4; c++)
          r[c * 40 +: 40] = {s[c][0][8:1], 32'h0};
      4'h3:
        for (int c = 0; c < 4; c++)
          r[c * 40 +: 40] = {s[c][0], 1'h0, s[c][1], 1'h0, s[c][2], 1'h0, s[c][3], 1'h0};
      4'h4:
      begin
        r[39:0] = {s[0][0], 3'h0, s[1][0][8:5], 24'h0};
        r[79:40] = {s[1][0][4:0], 3'h0, s[2][0][8:1], 24'h0};
        r[119:80] = {s[2][0][0], 3'h0, s[3][0], 3'h0, 24'h0};
      end
      4'h5:
      begin
        r[39:0] = {s[0][0][8:1], s[1][0][8:1], 24'h0};
        r[79:40] = {s[2][0][8:1], s[3][0][8:1], 24'h0};
      end
      4'h8:
        for (int c = 0; c < 4; c++)
          r[c * 40 +: 40] = {s[c][0], 3'h0, s[c][1], 3'h0, 16'h0};
      4'h9:
        for (int k = 0; k < 8; k++)
          r[k * 40 +: 40] = {s[k / 2][k % 2][8:1], 32'h0};
      default:
        r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [143:0] rnd144();
    logic [159:0] v;
    v = {$urandom, $urandom, $urandom, $urandom, $urandom};
    return v[143:0];
  endfunction

  task automatic chk_frame(logic [319:0] gd, logic [319:0] xd, logic [2:0] go, logic [2:0] xo);
    n_checks++;
    if (gd !== xd || go !== xo)
    begin
      err_count++;
      $display("[FAIL] %0t lane frame differs in mode %0d part %0d", $time, mode, part);
    end
  endtask

  task automatic chk_val(logic [7:0] got, logic [7:0] xp, string what);
    n_checks++;
    if (got !== xp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, xp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Expected frames queued at acceptance, only for supported modes
  always @(posedge CLK_SYS_IN)
    if (SAMPLE_VALID_IN && SAMPLE_READY_OUT === 1'b1 && mode >= 4'h1 && mode <= 4'h9)
      exp_q.push_back(map_frame(mode, part, SAMPLE_DATA_IN));

  always @(posedge CLK_SYS_IN)
    if (LANE_VALID_OUT === 1'b1 && LANE_READY_IN === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_val(8'h1, 8'h0, "frame with none pending");
      else
      begin
        ed = exp_q.pop_front();
        eo = 3'(OCT[mode]);
        case (mode)
          4'h1: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h2: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h3: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h4: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h5: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h6: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h7: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          4'h8: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
          default: chk_frame(LANE_DATA_OUT, ed, LANE_OCTETS_OUT, eo);
        endcase
      end
    end

  // Config changes only while idle; pins need several edges to settle
  task automatic set_cfg(logic [3:0] m, logic [1:0] p);
    int n;
    @(negedge CLK_SYS_IN);
    mode = m;
    part = p;
    repeat (8) @(negedge CLK_SYS_IN);
    n = (m >= 4'h1 && m <= 4'h9) ? LN[m][pidx(p)] : 0;
    chk_val(LANE_POWER_OUT, 8'((1 << n) - 1), "lane power");
    chk_val({7'h0, LINK_64B66B_OUT}, {7'h0, m >= 4'h4 && m <= 4'h8}, "encoding");
  endtask

  task automatic send(int n);
    repeat (n)
    begin
      @(negedge CLK_SYS_IN);
      SAMPLE_VALID_IN = 1'b1;
      SAMPLE_DATA_IN = rnd144();
      @(posedge CLK_SYS_IN);
      while (SAMPLE_READY_OUT !== 1'b1)
        @(posedge CLK_SYS_IN);
    end
    @(negedge CLK_SYS_IN);
    SAMPLE_VALID_IN = 1'b0;
  endtask

  task automatic drain;
    for (int i = 0; i < 400 && exp_q.size() != 0; i++)
      @(negedge CLK_SYS_IN);
    repeat (4) @(negedge CLK_SYS_IN);
    chk_val(8'(exp_q.size()), 8'h0, "frames lost");
    chk_val({7'h0, LANE_VALID_OUT}, 8'h0, "valid after drain");
  endtask

  initial
  begin
    void'($urandom(6908));
    SYS_RST_IN = 1'b1;
    SAMPLE_VALID_IN = 1'b0;
    SAMPLE_DATA_IN = '0;
    mode = 4'h0;
    part = 2'h0;
    busy = 8'h0;
    hold = 1'b0;
    repeat (10) @(negedge CLK_SYS_IN);
    SYS_RST_IN = 1'b0;
    for (int m = 1; m <= 9; m++)
      for (int p = 0; p < 4; p++)
      begin
        busy = 8'($urandom_range(70));
        set_cfg(4'(m), 2'(p));
        send(6);
        drain;
      end
    // Stalled receiver: output register, read stage and 16 buffer words fill, then drain
    hold = 1'b1;
    set_cfg(4'h3, 2'h0);
    taken = 0;
    for (int i = 0; i < 24; i++)
    begin
      @(negedge CLK_SYS_IN);
      SAMPLE_VALID_IN = 1'b1;
      SAMPLE_DATA_IN = rnd144();
      @(posedge CLK_SYS_IN);
      if (SAMPLE_READY_OUT !== 1'b1)
        break;
      taken++;
    end
    @(negedge CLK_SYS_IN);
    SAMPLE_VALID_IN = 1'b0;
    chk_val(8'(taken), 8'(lane_map_pkg::FIFO_DEPTH + 2), "buffer capacity");
    hold = 1'b0;
    drain;
    // Unsupported modes drop frames and power every lane down
    set_cfg(4'h0, 2'h1);
    send(3);
    drain;
    set_cfg(4'hb, 2'h0);
    send(3);
    drain;
    report_and_stop;
  end

  initial
  begin
    repeat (60000) @(posedge CLK_SYS_IN);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
`default_nettype wire
